// ==== eewc_top.sv ====
// Purpose: two-wire client front end of a 256-byte serial memory
// Assumes: host owns the clock line and all start and stop conditions
// Notes: line samples pass synchroniser and spike filter before decoding
// Notes on behaviour
// - select only when all chip-select pins match
// - data line driven low or released only
// - data changes only while clock low
// - falling data with clock high starts
// - rising data with clock high stops
// - one bit per clock pulse, sampled high
// - keep last sixteen bytes, oldest overwritten
// - receiver acknowledges every byte
// - no acknowledge during programming cycle
// - acknowledge low through whole clock high
// - host nack ends read, line released
// - respond only to fixed control code
// - chip-select bits ordered high to low pin
// - last control bit: one read, zero write
// - acknowledge match then enter read or write
// - byte after control byte is address
// - protect input high blocks array writes
// - filter spikes on clock and data
// - write cycle ends within five milliseconds
// - address pointer wraps top to zero
`timescale 1ns/1ps
module eewc_top #(
  parameter int WC_CYC = eewc_pkg::WC_CYC,
  parameter int FILT_CYC = eewc_pkg::FILT_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // two-wire bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // straps
  input wire logic chip_sel_pin_low,
  input wire logic chip_sel_pin_mid,
  input wire logic chip_sel_pin_high,
  input wire logic write_protect,
  // status
  output logic wr_busy,
  output logic selected
);
  localparam int WCW = $clog2(WC_CYC);
  localparam int AW = eewc_pkg::MEM_AW;
  localparam int PW = eewc_pkg::PAGE_AW;

  logic rst_s1_r;
  logic rst_q_r;
  logic [1:0] bus_f;
  logic [3:0] pins_f;
  logic scl_f;
  logic sda_f;
  logic scl_q_r;
  logic sda_q_r;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  eewc_pkg::eewc_state_e state_r;
  eewc_pkg::eewc_state_e ret_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] sh_r;
  logic [7:0] byte_in;
  logic ack_half_r;
  logic sda_oe_r;
  logic match;
  logic rx_done;
  logic tx_load;
  logic [7:0] tx_byte;
  logic [AW-1:0] addr_ptr_r;
  logic [7:0] pbuf_r [0:eewc_pkg::PAGE_BYTES-1];
  logic [eewc_pkg::PAGE_BYTES-1:0] pvalid_r;
  logic wr_pend_r;
  logic commit_r;
  logic [PW-1:0] cidx_r;
  logic wc_start;
  logic busy_r;
  logic [WCW-1:0] wc_cnt_r;
  logic mem_we;
  logic rd_mode;
  logic rd_issue;
  logic inflight_r;
  logic [AW-1:0] pf_ptr_r;
  logic [7:0] mem_rdata;
  logic [7:0] rb0_r;
  logic [7:0] rb1_r;
  logic [1:0] rb_cnt_r;
  logic rb_in_ready;
  logic rb_out_valid;
  logic rb_push;
  logic rb_pop;

  // reset release through two flops
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_r <= 1'b0;
      rst_q_r <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_q_r <= rst_s1_r;
    end
  end

  // bus lines with spike filter, straps with plain synchronisers
  eewc_sync_filt #(.WIDTH(2), .FILT_CYC(FILT_CYC), .INIT(eewc_pkg::BUS_IDLE)) u_bus_sync (
    .clk(sys_clk),
    .rst_n(rst_q_r),
    .din({scl_in, sda_in}),
    .dout(bus_f)
  );

  eewc_sync_filt #(.WIDTH(4), .FILT_CYC(1), .INIT(eewc_pkg::PINS_INIT)) u_pin_sync (
    .clk(sys_clk),
    .rst_n(rst_q_r),
    .din({write_protect, chip_sel_pin_high, chip_sel_pin_mid, chip_sel_pin_low}),
    .dout(pins_f)
  );

  assign scl_f = bus_f[1];
  assign sda_f = bus_f[0];

  always_ff @(posedge sys_clk or negedge rst_q_r)
  begin
    if (!rst_q_r)
    begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end
    else
    begin
      scl_q_r <= scl_f;
      sda_q_r <= sda_f;
    end
  end

  // single-cycle events from the filtered copies
  assign scl_rise = scl_f & ~scl_q_r;
  assign scl_fall = ~scl_f & scl_q_r;
  assign start_det = scl_f & scl_q_r & sda_q_r & ~sda_f;
  assign stop_det = scl_f & scl_q_r & ~sda_q_r & sda_f;

  assign byte_in = {sh_r[6:0], sda_f};
  // code, chip select (high pin first) and idle write engine
  assign match = (byte_in[eewc_pkg::CODE_MSB:eewc_pkg::CODE_LSB] == eewc_pkg::CTRL_CODE)
    && (byte_in[eewc_pkg::CS_MSB:eewc_pkg::CS_LSB] == pins_f[2:0])
    && !busy_r;
  assign rx_done = scl_rise && (bit_cnt_r == 3'h7) && !start_det && !stop_det;
  assign tx_load = scl_fall && !start_det && !stop_det
    && (((state_r == eewc_pkg::EEWC_ACK) && ack_half_r && (ret_r == eewc_pkg::EEWC_RDATA))
    || (state_r == eewc_pkg::EEWC_RLOAD));
  // an empty buffer sends released bits rather than stale data
  assign tx_byte = rb_out_valid ? rb0_r : eewc_pkg::IDLE_BYTE;

  // bit level sequencing; all drive changes happen on clock falls
  always_ff @(posedge sys_clk or negedge rst_q_r)
  begin
    if (!rst_q_r)
    begin
      state_r <= eewc_pkg::EEWC_IDLE;
      ret_r <= eewc_pkg::EEWC_IDLE;
      bit_cnt_r <= 3'h0;
      sh_r <= 8'h00;
      ack_half_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end
    else if (start_det)
    begin
      state_r <= eewc_pkg::EEWC_CTRL;
      ret_r <= eewc_pkg::EEWC_IDLE;
      bit_cnt_r <= 3'h0;
      ack_half_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end
    else if (stop_det)
    begin
      state_r <= eewc_pkg::EEWC_IDLE;
      ret_r <= eewc_pkg::EEWC_IDLE;
      ack_half_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        eewc_pkg::EEWC_CTRL, eewc_pkg::EEWC_ADDR, eewc_pkg::EEWC_WDATA:
        begin
          if (scl_rise)
          begin
            sh_r <= byte_in;
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == 3'h7)
            begin
              ack_half_r <= 1'b0;
              if (state_r != eewc_pkg::EEWC_CTRL)
              begin
                state_r <= eewc_pkg::EEWC_ACK;
                ret_r <= eewc_pkg::EEWC_WDATA;
              end
              else if (match)
              begin
                state_r <= eewc_pkg::EEWC_ACK;
                ret_r <= byte_in[eewc_pkg::RW_BIT] ? eewc_pkg::EEWC_RDATA
                  : eewc_pkg::EEWC_ADDR;
              end
              else
                state_r <= eewc_pkg::EEWC_WAIT;
            end
          end
        end
        eewc_pkg::EEWC_ACK:
        begin
          if (scl_fall)
          begin
            if (!ack_half_r)
            begin
              sda_oe_r <= 1'b1;
              ack_half_r <= 1'b1;
            end
            else
            begin
              ack_half_r <= 1'b0;
              bit_cnt_r <= 3'h0;
              state_r <= ret_r;
              if (ret_r == eewc_pkg::EEWC_RDATA)
              begin
                sh_r <= tx_byte;
                sda_oe_r <= ~tx_byte[7];
              end
              else
                sda_oe_r <= 1'b0;
            end
          end
        end
        eewc_pkg::EEWC_RDATA:
        begin
          if (scl_rise)
          begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == 3'h7)
              state_r <= eewc_pkg::EEWC_RREL;
          end
          else if (scl_fall)
          begin
            sh_r <= {sh_r[6:0], 1'b1};
            sda_oe_r <= ~sh_r[6];
          end
        end
        eewc_pkg::EEWC_RREL:
        begin
          if (scl_fall)
          begin
            sda_oe_r <= 1'b0;
            state_r <= eewc_pkg::EEWC_RACK;
          end
        end
        eewc_pkg::EEWC_RACK:
        begin
          // host nack leaves the line released until stop
          if (scl_rise)
            state_r <= sda_f ? eewc_pkg::EEWC_WAIT : eewc_pkg::EEWC_RLOAD;
        end
        eewc_pkg::EEWC_RLOAD:
        begin
          if (scl_fall)
          begin
            sh_r <= tx_byte;
            sda_oe_r <= ~tx_byte[7];
            bit_cnt_r <= 3'h0;
            state_r <= eewc_pkg::EEWC_RDATA;
          end
        end
        eewc_pkg::EEWC_IDLE, eewc_pkg::EEWC_WAIT:
        begin
          sda_oe_r <= 1'b0;
        end
        default:
        begin
          state_r <= eewc_pkg::EEWC_IDLE;
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end

  // address pointer: loaded by the address byte, stepped per byte
  always_ff @(posedge sys_clk or negedge rst_q_r)
  begin
    if (!rst_q_r)
      addr_ptr_r <= '0;
    else if (rx_done && (state_r == eewc_pkg::EEWC_ADDR))
      addr_ptr_r <= byte_in;
    else if (rx_done && (state_r == eewc_pkg::EEWC_WDATA))
      addr_ptr_r[PW-1:0] <= addr_ptr_r[PW-1:0] + 1'b1;
    else if (tx_load)
      addr_ptr_r <= addr_ptr_r + 1'b1;
  end

  // page buffer indexed by the low pointer bits, so overflow overwrites oldest
  always_ff @(posedge sys_clk or negedge rst_q_r)
  begin
    if (!rst_q_r)
    begin
      pvalid_r <= '0;
      wr_pend_r <= 1'b0;
      commit_r <= 1'b0;
      cidx_r <= '0;
    end
    else if (commit_r)
    begin
      cidx_r <= cidx_r + 1'b1;
      if (cidx_r == PW'(eewc_pkg::PAGE_BYTES - 1))
      begin
        commit_r <= 1'b0;
        pvalid_r <= '0;
      end
    end
    else if (wc_start)
    begin
      commit_r <= 1'b1;
      cidx_r <= '0;
      wr_pend_r <= 1'b0;
    end
    else if (start_det)
    begin
      // a repeated start abandons a half-sent write
      pvalid_r <= '0;
      wr_pend_r <= 1'b0;
    end
    else if (rx_done && (state_r == eewc_pkg::EEWC_WDATA))
    begin
      pbuf_r[addr_ptr_r[PW-1:0]] <= byte_in;
      pvalid_r[addr_ptr_r[PW-1:0]] <= 1'b1;
      wr_pend_r <= 1'b1;
    end
  end

  // protected writes still run the full cycle, only the array stays untouched
  assign mem_we = commit_r && pvalid_r[cidx_r] && !pins_f[3];
  assign wc_start = stop_det && wr_pend_r;

  // programming cycle timer
  always_ff @(posedge sys_clk or negedge rst_q_r)
  begin
    if (!rst_q_r)
    begin
      busy_r <= 1'b0;
      wc_cnt_r <= '0;
    end
    else if (wc_start)
    begin
      busy_r <= 1'b1;
      wc_cnt_r <= WCW'(WC_CYC - 1);
    end
    else if (busy_r)
    begin
      if (wc_cnt_r == '0)
        busy_r <= 1'b0;
      else
        wc_cnt_r <= wc_cnt_r - 1'b1;
    end
  end

  // read prefetch into a two-entry buffer; full buffer stalls issue
  assign rd_mode = (ret_r == eewc_pkg::EEWC_RDATA) && (state_r != eewc_pkg::EEWC_IDLE)
    && (state_r != eewc_pkg::EEWC_WAIT) && (state_r != eewc_pkg::EEWC_CTRL);
  assign rb_in_ready = rb_cnt_r < 2'(eewc_pkg::RBUF_DEPTH);
  assign rb_out_valid = rb_cnt_r != 2'h0;
  assign rd_issue = rd_mode && !inflight_r && rb_in_ready && !(rb_cnt_r == 2'h1 && !rb_pop);
  assign rb_push = inflight_r && rb_in_ready && rd_mode;
  assign rb_pop = tx_load && rb_out_valid;

  always_ff @(posedge sys_clk or negedge rst_q_r)
  begin
    if (!rst_q_r)
    begin
      pf_ptr_r <= '0;
      inflight_r <= 1'b0;
    end
    else if (!rd_mode)
    begin
      pf_ptr_r <= addr_ptr_r;
      inflight_r <= 1'b0;
    end
    else
    begin
      inflight_r <= rd_issue;
      if (rd_issue)
        pf_ptr_r <= pf_ptr_r + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_q_r)
  begin
    if (!rst_q_r)
    begin
      rb_cnt_r <= 2'h0;
      rb0_r <= 8'h00;
      rb1_r <= 8'h00;
    end
    else if (!rd_mode)
      rb_cnt_r <= 2'h0;
    else
    begin
      case ({rb_push, rb_pop})
        2'h2:
        begin
          if (rb_cnt_r == 2'h0)
            rb0_r <= mem_rdata;
          else
            rb1_r <= mem_rdata;
          rb_cnt_r <= rb_cnt_r + 2'h1;
        end
        2'h1:
        begin
          rb0_r <= rb1_r;
          rb_cnt_r <= rb_cnt_r - 2'h1;
        end
        2'h3:
        begin
          if (rb_cnt_r == 2'h1)
            rb0_r <= mem_rdata;
          else
          begin
            rb0_r <= rb1_r;
            rb1_r <= mem_rdata;
          end
        end
        default:
        begin
          rb_cnt_r <= rb_cnt_r;
        end
      endcase
    end
  end

  eewc_mem #(.AW(AW), .DW(eewc_pkg::DATA_W)) u_mem (
    .clk(sys_clk),
    .rst_n(rst_q_r),
    .we(mem_we),
    .waddr({addr_ptr_r[AW-1:PW], cidx_r}),
    .wdata(pbuf_r[cidx_r]),
    .re(rd_issue),
    .raddr(pf_ptr_r),
    .rdata(mem_rdata)
  );

  assign sda_out = 1'b0;
  assign sda_oe = sda_oe_r;
  assign wr_busy = busy_r;
  assign selected = (state_r != eewc_pkg::EEWC_IDLE) && (state_r != eewc_pkg::EEWC_WAIT)
    && (state_r != eewc_pkg::EEWC_CTRL);

  sequence s_ctrl_ok;
    (state_r == eewc_pkg::EEWC_CTRL) && rx_done && match;
  endsequence

  property p_low_only;
    @(posedge sys_clk) disable iff (!rst_q_r) sda_oe |-> (sda_out == 1'b0);
  endproperty
  a_low_only: assert property (p_low_only) else $error("data line driven high");

  property p_oe_on_fall;
    @(posedge sys_clk) disable iff (!rst_q_r) $rose(sda_oe_r) |-> $past(scl_fall);
  endproperty
  a_oe_on_fall: assert property (p_oe_on_fall) else $error("drive began off a clock fall");

  property p_start;
    @(posedge sys_clk) disable iff (!rst_q_r)
      start_det |=> (state_r == eewc_pkg::EEWC_CTRL) && !sda_oe_r;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");

  property p_stop;
    @(posedge sys_clk) disable iff (!rst_q_r)
      stop_det |=> (state_r == eewc_pkg::EEWC_IDLE) && !sda_oe_r;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not taken");

  property p_busy_quiet;
    @(posedge sys_clk) disable iff (!rst_q_r) busy_r |-> !sda_oe_r && !selected;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("acknowledge during write cycle");

  property p_nomatch;
    @(posedge sys_clk) disable iff (!rst_q_r)
      ((state_r == eewc_pkg::EEWC_CTRL) && rx_done && !match) |=> (state_r == eewc_pkg::EEWC_WAIT);
  endproperty
  a_nomatch: assert property (p_nomatch) else $error("foreign address answered");

  property p_select;
    @(posedge sys_clk) disable iff (!rst_q_r)
      s_ctrl_ok |=> (state_r == eewc_pkg::EEWC_ACK)
        && ((ret_r == eewc_pkg::EEWC_RDATA) == $past(sda_f));
  endproperty
  a_select: assert property (p_select) else $error("wrong direction after control byte");

  property p_wp;
    @(posedge sys_clk) disable iff (!rst_q_r) pins_f[3] |-> !mem_we;
  endproperty
  a_wp: assert property (p_wp) else $error("array written while protected");

  property p_wc_len;
    @(posedge sys_clk) disable iff (!rst_q_r)
      wc_start |=> busy_r && (wc_cnt_r == WCW'(WC_CYC - 1));
  endproperty
  a_wc_len: assert property (p_wc_len) else $error("write cycle length wrong");

  property p_wrap;
    @(posedge sys_clk) disable iff (!rst_q_r)
      (tx_load && (addr_ptr_r == 8'hff)) |=> (addr_ptr_r == 8'h00);
  endproperty
  a_wrap: assert property (p_wrap) else $error("pointer did not wrap");

  property p_page;
    @(posedge sys_clk) disable iff (!rst_q_r)
      (rx_done && (state_r == eewc_pkg::EEWC_WDATA) && !commit_r)
        |=> pvalid_r[$past(addr_ptr_r[PW-1:0])] && (addr_ptr_r[AW-1:PW] == $past(addr_ptr_r[AW-1:PW]));
  endproperty
  a_page: assert property (p_page) else $error("page byte not held");
endmodule

// ==== eewc_pkg.sv ====
// Purpose: shared constants and state encoding of the two-wire client front end
// Assumes: 200 MHz system clock
// Notes: every timing count is derived from the time in its own unit
package eewc_pkg;
  localparam int CLK_MHZ = 200;
  // control byte layout
  localparam logic [3:0] CTRL_CODE = 4'ha;
  localparam int CODE_MSB = 7;
  localparam int CODE_LSB = 4;
  localparam int CS_MSB = 3;
  localparam int CS_LSB = 1;
  localparam int RW_BIT = 0;
  // memory and page buffer
  localparam int MEM_AW = 8;
  localparam int DATA_W = 8;
  localparam int PAGE_BYTES = 16;
  localparam int PAGE_AW = 4;
  localparam logic [7:0] IDLE_BYTE = 8'hff;
  // spike suppression, a longest time, rounded down
  localparam int TSP_NS = 50;
  localparam int FILT_CYC = (TSP_NS * CLK_MHZ) / 1000;
  // internal write cycle, a longest time, rounded down
  localparam int WC_MS = 5;
  localparam int WC_CYC = WC_MS * CLK_MHZ * 1000;
  // reset levels of the synchronised lines
  localparam logic [1:0] BUS_IDLE = 2'h3;
  localparam logic [3:0] PINS_INIT = 4'h0;
  // read buffer depth
  localparam int RBUF_DEPTH = 2;

  typedef enum logic [3:0] {
    EEWC_IDLE  = 4'h0,
    EEWC_WAIT  = 4'h1,
    EEWC_CTRL  = 4'h2,
    EEWC_ADDR  = 4'h3,
    EEWC_WDATA = 4'h4,
    EEWC_ACK   = 4'h5,
    EEWC_RDATA = 4'h6,
    EEWC_RREL  = 4'h7,
    EEWC_RACK  = 4'h8,
    EEWC_RLOAD = 4'h9
  } eewc_state_e;
endpackage

// ==== eewc_sync_filt.sv ====
// Purpose: three-flop synchroniser with a stability filter per bit
// Assumes: inputs asynchronous to clk
// Notes: a change is taken once flops two and three agree for FILT_CYC cycles
`timescale 1ns/1ps
module eewc_sync_filt #(
  parameter int WIDTH = 1,
  parameter int FILT_CYC = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // lines
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  localparam int CW = (FILT_CYC > 1) ? $clog2(FILT_CYC) : 1;

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
    end
    else
    begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  for (genvar i = 0; i < WIDTH; i++)
  begin : g_bit
    logic [CW-1:0] cnt_r;
    // short spikes restart the count and never reach the output
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        cnt_r <= '0;
        dout[i] <= INIT[i];
      end
      else if ((s2_r[i] == s3_r[i]) && (s3_r[i] != dout[i]))
      begin
        if (cnt_r == CW'(FILT_CYC - 1))
        begin
          dout[i] <= s3_r[i];
          cnt_r <= '0;
        end
        else
          cnt_r <= cnt_r + 1'b1;
      end
      else
        cnt_r <= '0;
    end
  end
endmodule

// ==== eewc_mem.sv ====
// Purpose: byte array with one write port and a registered read port
// Assumes: no read and write to the same address in one cycle
// Notes: array contents are not reset
`timescale 1ns/1ps
module eewc_mem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  // read port
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem_r [0:(1<<AW)-1];

  always_ff @(posedge clk)
  begin
    if (we)
      mem_r[waddr] <= wdata;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= '0;
    else if (re)
      rdata <= mem_r[raddr];
  end
endmodule

// ==== eewc_host_model.sv ====
// Purpose: behavioural two-wire bus host for the client front end
// Assumes: data line resolved outside with a pull-up
// Notes: clock stands high between frames; steps are quarter link periods
`timescale 1ns/1ps
module eewc_host_model #(
  parameter realtime PERIOD = 125.0
) (
  // bus
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  localparam realtime Q = PERIOD / 4.0;
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // also serves as repeated start
  task automatic start();
    #Q sda_low = 1'b0;
    #Q scl = 1'b1;
    #Q sda_low = 1'b1;
    #Q scl = 1'b0;
  endtask
  task automatic stop();
    #Q sda_low = 1'b1;
    #Q scl = 1'b1;
    #Q sda_low = 1'b0;
    #Q;
  endtask
  task automatic xfer_bit(input logic b, output logic r);
    #Q sda_low = !b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      xfer_bit(d[i], r);
    xfer_bit(1'b1, r);
    ack = !r;
  endtask
  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      xfer_bit(1'b1, d[i]);
    xfer_bit(!ack, r);
  endtask
  // clock glitch while low, shorter than the filter window: must not count as a bit
  task automatic spike();
    #Q scl = 1'b1;
    #3 scl = 1'b0;
  endtask
endmodule

// ==== testbench.sv ====
// Purpose: self-checking bench for the two-wire client front end
// Assumes: shortened write cycle and filter for a 125 ns link clock
// Notes: expected memory contents kept in the bench
`timescale 1ns/1ps
module testbench;
  localparam int WC = 400;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic scl;
  logic sda_low;
  logic sda_out;
  logic sda_oe;
  logic wr_busy;
  logic selected;
  logic [2:0] pins = 3'h0;
  logic write_protect = 1'b0;
  logic [15:0] seed = 16'had92;
  logic [7:0] mem_exp [256];
  logic known [256];
  int fails = 0;
  int tests_run = 0;
  // open drain: low if either party pulls
  wire logic sda = (sda_oe ? sda_out : 1'b1) & !sda_low;

  eewc_top #(.WC_CYC(WC), .FILT_CYC(2)) i_eewc_top (
    .sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .chip_sel_pin_low(pins[0]),
    .chip_sel_pin_mid(pins[1]), .chip_sel_pin_high(pins[2]),
    .write_protect(write_protect), .wr_busy(wr_busy), .selected(selected));
  eewc_host_model i_eewc_host_model (.scl(scl), .sda_low(sda_low), .sda(sda));

  initial
  begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // page slots roll within the lower nibble, upper nibble kept
  function automatic logic [7:0] slot(input logic [7:0] base, input int k);
    return {base[7:4], base[3:0] + 4'(k)};
  endfunction
  task automatic rnd(output logic [7:0] v);
    seed = lfsr_next(seed);
    v = seed[7:0];
  endtask
  task automatic wrap_up();
    $display("tests_run %0d fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ctrl(input logic [7:0] b, input logic exp_ack);
    logic a;
    i_eewc_host_model.start();
    i_eewc_host_model.wr_byte(b, a);
    check(8'(a), 8'(exp_ack));
    check(8'(selected), 8'(exp_ack));
  endtask
  task automatic finish_write(input logic poll);
    int cnt;
    cnt = 0;
    i_eewc_host_model.stop();
    repeat (4) @(posedge sys_clk);
    check(8'(wr_busy), 8'h1);
    if (poll)
    begin
      ctrl({eewc_pkg::CTRL_CODE, pins, 1'b0}, 1'b0);
      i_eewc_host_model.stop();
    end
    while (wr_busy && cnt < 1000)
    begin
      @(posedge sys_clk);
      cnt++;
    end
    if (cnt == 1000)
    begin
      fails++;
      wrap_up();
    end
    if (!poll)
      check(8'(cnt >= WC - 20 && cnt <= WC + 2), 8'h1);
  endtask
  task automatic page_write(input logic [7:0] base, input int n, input logic poll);
    logic a;
    logic [7:0] d;
    ctrl({eewc_pkg::CTRL_CODE, pins, 1'b0}, 1'b1);
    i_eewc_host_model.wr_byte(base, a);
    check(8'(a), 8'h1);
    for (int k = 0; k < n; k++)
    begin
      rnd(d);
      i_eewc_host_model.wr_byte(d, a);
      check(8'(a), 8'h1);
      if (!write_protect)
      begin
        mem_exp[slot(base, k)] = d;
        known[slot(base, k)] = 1'b1;
      end
    end
    finish_write(poll);
  endtask
  task automatic seq_read(input logic [7:0] addr, input int n);
    logic a;
    logic [7:0] d;
    ctrl({eewc_pkg::CTRL_CODE, pins, 1'b0}, 1'b1);
    i_eewc_host_model.wr_byte(addr, a);
    ctrl({eewc_pkg::CTRL_CODE, pins, 1'b1}, 1'b1);
    for (int k = 0; k < n; k++)
    begin
      i_eewc_host_model.rd_byte(k < n - 1, d);
      if (known[8'(addr + k)])
        check(d, mem_exp[8'(addr + k)]);
    end
    repeat (20) @(posedge sys_clk);
    check({6'h0, sda_oe, sda_out}, 8'h0);
    i_eewc_host_model.stop();
  endtask

  initial
  begin
    logic [7:0] v;
    logic a;
    for (int i = 0; i < 256; i++)
      known[i] = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    rnd(v);
    pins = v[2:0];
    repeat (30) @(posedge sys_clk);
    check({5'h0, sda_oe, wr_busy, selected}, 8'h0);
    for (int c = 0; c < 8; c++)
    begin
      ctrl({eewc_pkg::CTRL_CODE, 3'(c), 1'b0}, 3'(c) == pins);
      i_eewc_host_model.stop();
    end
    for (int c = 0; c < 16; c++)
    begin
      ctrl({4'(c), pins, 1'b0}, 4'(c) == eewc_pkg::CTRL_CODE);
      i_eewc_host_model.stop();
    end
    // a counted glitch would shift the address byte and move its acknowledge
    ctrl({eewc_pkg::CTRL_CODE, pins, 1'b0}, 1'b1);
    i_eewc_host_model.spike();
    i_eewc_host_model.wr_byte(8'h00, a);
    check(8'(a), 8'h1);
    i_eewc_host_model.stop();
    rnd(v);
    page_write(v, 18, 1'b0);
    seq_read({v[7:4], 4'h0}, 16);
    page_write(8'hfe, 2, 1'b1);
    page_write(8'h00, 1, 1'b0);
    seq_read(8'hfe, 3);
    @(posedge sys_clk);
    #1 write_protect = 1'b1;
    page_write(8'hfe, 1, 1'b0);
    @(posedge sys_clk);
    #1 write_protect = 1'b0;
    seq_read(8'hfe, 1);
    // part without the high pin: strap tied low, host sends zero there
    @(posedge sys_clk);
    #1 pins[2] = 1'b0;
    ctrl({eewc_pkg::CTRL_CODE, 1'b0, pins[1:0], 1'b0}, 1'b1);
    i_eewc_host_model.stop();
    wrap_up();
  end

  initial
  begin
    #400000;
    fails++;
    wrap_up();
  end
endmodule
